/* logic/tpo_pkg.sv */
package tpo_pkg;
	// ----------------------------------------
	// bus geometry
	// ----------------------------------------
	localparam int          ADR_W      = 16;
	localparam int          DAT_W      = 32;
	localparam int          REG_W      = 8;
	localparam int          IDX_W      = 12;
	localparam logic [1:0]  ADR_LANE   = 2'h0;
	localparam logic [1:0]  ADR_TOP    = 2'h0;

	// ----------------------------------------
	// register indices, byte address is four times the index
	// ----------------------------------------
	localparam logic [IDX_W-1:0] IDX_LOW   = 12'h59c;
	localparam logic [IDX_W-1:0] IDX_HIGH  = 12'h59d;
	localparam logic [IDX_W-1:0] IDX_CTRL0 = 12'h59e;
	localparam logic [IDX_W-1:0] IDX_CTRL1 = 12'h59f;
	localparam logic [IDX_W-1:0] IDX_IRQ   = 12'h5a0;
	localparam logic [REG_W-1:0] REG_RST   = 8'h00;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CF_RUN     = 7;
	localparam int CF_RSVD    = 6;
	localparam int CF_OUT     = 5;
	localparam int CF_WIDE    = 4;
	localparam int CF_POST_HI = 3;
	localparam int CF_POST_LO = 0;
	localparam int CS_CLK_HI  = 7;
	localparam int CS_CLK_LO  = 5;
	localparam int CS_UNSYNC  = 4;
	localparam int CS_PRE_HI  = 3;
	localparam int CS_PRE_LO  = 0;
	localparam int IR_FLAG    = 0;
	localparam int IR_EN      = 1;

	// ----------------------------------------
	// count clock sources
	// ----------------------------------------
	localparam logic [2:0] SRC_PIN    = 3'h0;
	localparam logic [2:0] SRC_PIN_N  = 3'h1;
	localparam logic [2:0] SRC_INSTR  = 3'h2;
	localparam logic [2:0] SRC_FAST   = 3'h3;
	localparam logic [2:0] SRC_SLOW   = 3'h4;
	localparam logic [2:0] SRC_MED    = 3'h5;
	localparam logic [2:0] SRC_SEC    = 3'h6;
	localparam logic [2:0] SRC_LCELL  = 3'h7;

	// ----------------------------------------
	// divider widths and counts
	// ----------------------------------------
	localparam int                SEL_W     = 4;
	localparam int                PRE_W     = 15;
	localparam logic [PRE_W-1:0]  PRE_ONE   = 15'h0001;
	localparam logic [1:0]        INSTR_END = 2'h3;
	localparam logic [15:0]       WIDE_MAX  = 16'hffff;
	localparam logic [15:0]       WIDE_ONE  = 16'h0001;
	localparam logic [REG_W-1:0]  LOW_ONE   = 8'h01;
endpackage : tpo_pkg

/* logic/tpo_scale_if.sv */
`timescale 1ns/100ps
interface tpo_scale_if;
	import tpo_pkg::*;
	logic             clear;
	logic             tick_in;
	logic [SEL_W-1:0] ratio;
	logic             tick_out;

	modport engine (output clear, output tick_in, output ratio, input tick_out);
	modport unit   (input clear, input tick_in, input ratio, output tick_out);
endinterface : tpo_scale_if

/* logic/tpo_prescale.sv */
`timescale 1ns/100ps
module tpo_prescale (
	input wire logic clk,       // main clock
	input wire logic rst,       // sync reset, high
	tpo_scale_if.unit s         // tick in, divided tick out
);
	import tpo_pkg::*;

	logic [PRE_W-1:0] cnt_ff;
	logic [PRE_W-1:0] mask;

	// power-of-two ratio: wraps to all ones at field value fifteen
	assign mask       = (PRE_ONE << s.ratio) - PRE_ONE;
	assign s.tick_out = s.tick_in && ((cnt_ff & mask) == mask);

	always_ff @(posedge clk) begin
		if (rst || s.clear) begin
			cnt_ff <= '0;
		end else if (s.tick_out) begin
			cnt_ff <= '0;
		end else if (s.tick_in) begin
			cnt_ff <= cnt_ff + PRE_ONE;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	pre_clear_a: assert property (s.clear |=> cnt_ff == '0)
		else $error("prescaler not cleared");
	pre_one_a: assert property ((s.ratio == '0 && s.tick_in) |-> s.tick_out)
		else $error("prescaler 1:1 dropped a tick");
endmodule : tpo_prescale

/* logic/tpo_postscale.sv */
`timescale 1ns/100ps
module tpo_postscale (
	input wire logic clk,       // main clock
	input wire logic rst,       // sync reset, high
	tpo_scale_if.unit s         // event in, scaled event out
);
	import tpo_pkg::*;

	logic [SEL_W-1:0] cnt_ff;

	// field value n gives one output per n+1 events
	assign s.tick_out = s.tick_in && (cnt_ff == s.ratio);

	always_ff @(posedge clk) begin
		if (rst || s.clear) begin
			cnt_ff <= '0;
		end else if (s.tick_out) begin
			cnt_ff <= '0;
		end else if (s.tick_in) begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	post_clear_a: assert property (s.clear |=> cnt_ff == '0)
		else $error("postscaler not cleared");
	post_wrap_a: assert property ((s.tick_in && !s.clear && cnt_ff == s.ratio) |=> cnt_ff == '0)
		else $error("postscaler did not wrap at ratio");
	post_step_a: assert property ((s.tick_in && !s.clear && cnt_ff != s.ratio)
		|=> cnt_ff == $past(cnt_ff) + 4'h1)
		else $error("postscaler did not advance");
endmodule : tpo_postscale

/* logic/tpo_top.sv */
`timescale 1ns/100ps
// What this block does
// - output divided by sixteen selectable postscaler ratios
// - postscaler cleared by low, control writes, reset
// - output toggles at each postscaler terminal event
// - toggle output offered to pin select, peripherals
// - toggle level readable at control one bit five
// - toggle sets flag; flag and enable request interrupt
// - flag set once every field plus one events
// - synchronised input stops counting during sleep
// - unsynchronised input counts in sleep, wakes device
// - control one bit seven enables timer, resets zero
// - control one bit four selects sixteen-bit mode
// - postscaler field bits three:zero, ratio field plus one
// - control two bits seven:five pick count clock
// - control two bit four drops input synchronisation
// - prescaler field gives ratio two to field power
// - eight-bit mode restarts low at period value
// - sixteen-bit mode high and low form count
// - clock source encoding of eight sources
// - match against buffered period, buffer reloads then
// - sixteen-bit mode: low read latches high; low write loads high
// - sixteen-bit count rolls ffff to zero freely
module tpo_top
(
	input  wire logic                      REF_CLK,    // 40 MHz clock
	input  wire logic                      RESET,      // sync reset, high
	input  wire logic                      WB_CYC_I,   // bus cycle
	input  wire logic                      WB_STB_I,   // strobe
	input  wire logic                      WB_WE_I,    // write enable
	input  wire logic [tpo_pkg::ADR_W-1:0] WB_ADR_I,   // byte address
	input  wire logic [3:0]                WB_SEL_I,   // byte selects
	input  wire logic [tpo_pkg::DAT_W-1:0] WB_DAT_I,   // write data
	output logic      [tpo_pkg::DAT_W-1:0] WB_DAT_O,   // read data
	output logic                           WB_ACK_O,   // acknowledge
	input  wire logic                      SLEEP,      // device in sleep
	input  wire logic                      COUNT_PIN,  // count pin input
	input  wire logic                      FAST_OSC,   // fast internal osc
	input  wire logic                      SLOW_OSC,   // slow internal osc
	input  wire logic                      MED_OSC,    // 500 kHz internal osc
	input  wire logic                      SEC_OSC,    // secondary osc
	input  wire logic                      LCELL_OUT,  // logic cell one output
	output logic                           TOGGLE_OUT, // timer toggle output
	output logic                           IRQ_REQ,    // interrupt request
	output logic                           WAKE_REQ    // wake from sleep
);
	import tpo_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [REG_W-1:0] low_ff;
	logic [REG_W-1:0] cnt_hi_ff;
	logic [REG_W-1:0] hi_ff;
	logic [REG_W-1:0] buf_ff;
	logic [REG_W-1:0] ctrl0_ff;
	logic [REG_W-1:0] ctrl1_ff;
	logic             tog_ff;
	logic             flag_ff;
	logic             ie_ff;
	logic             ack_ff;
	logic [DAT_W-1:0] dat_ff;
	logic [1:0]       div_ff;
	logic             src_q_ff;
	logic             pend_ff;

	logic [IDX_W-1:0] idx;
	logic             hit;
	logic             acc_go;
	logic             wr_go;
	logic             rd_go;
	logic             scl_clr;
	logic             instr_en;
	logic             src_lvl;
	logic             src_edge;
	logic             count_in;
	logic             run;
	logic             wide;
	logic             unsync;
	logic             step;
	logic             match;
	logic             event_hit;
	logic [15:0]      nxt_count;
	logic [REG_W-1:0] rd_val;

	tpo_scale_if pre_bus ();
	tpo_scale_if post_bus ();

	assign run    = ctrl0_ff[CF_RUN];
	assign wide   = ctrl0_ff[CF_WIDE];
	assign unsync = ctrl1_ff[CS_UNSYNC];

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	assign idx    = WB_ADR_I[IDX_W+1:2];
	assign hit    = (WB_ADR_I[1:0] == ADR_LANE) && (WB_ADR_I[ADR_W-1:IDX_W+2] == ADR_TOP);
	assign acc_go = WB_CYC_I && WB_STB_I && !ack_ff;
	assign wr_go  = acc_go && WB_WE_I && WB_SEL_I[0] && hit;
	assign rd_go  = acc_go && !WB_WE_I && hit;

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= acc_go;
		end
	end

	always_comb begin
		rd_val = REG_RST;
		case (idx)
			IDX_LOW:   rd_val = low_ff;
			IDX_HIGH:  rd_val = hi_ff;
			IDX_CTRL0: rd_val = {ctrl0_ff[CF_RUN], 1'b0, tog_ff, ctrl0_ff[CF_WIDE:0]};
			IDX_CTRL1: rd_val = ctrl1_ff;
			IDX_IRQ:   rd_val = {6'h00, ie_ff, flag_ff};
			default:   rd_val = REG_RST;
		endcase
	end

	// unmapped reads return zero but are still acknowledged
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			dat_ff <= '0;
		end else if (acc_go) begin
			dat_ff <= rd_go ? {24'h000000, rd_val} : '0;
		end
	end

	assign WB_ACK_O = ack_ff;
	assign WB_DAT_O = dat_ff;

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ctrl0_ff <= REG_RST;
			ctrl1_ff <= REG_RST;
		end else if (wr_go && idx == IDX_CTRL0) begin
			// status bit and reserved bit never store
			ctrl0_ff <= WB_DAT_I[REG_W-1:0] & ~(8'h01 << CF_OUT) & ~(8'h01 << CF_RSVD);
		end else if (wr_go && idx == IDX_CTRL1) begin
			ctrl1_ff <= WB_DAT_I[REG_W-1:0];
		end
	end

	assign scl_clr = wr_go && (idx == IDX_LOW || idx == IDX_CTRL0 || idx == IDX_CTRL1);

	// ----------------------------------------
	// count clock selection
	// ----------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			div_ff <= 2'h0;
		end else if (!SLEEP) begin
			div_ff <= div_ff + 2'h1;
		end
	end

	// instruction clock is a quarter rate enable, absent in sleep
	assign instr_en = (div_ff == INSTR_END) && !SLEEP;

	always_comb begin
		src_lvl = 1'b0;
		case (ctrl1_ff[CS_CLK_HI:CS_CLK_LO])
			SRC_PIN:   src_lvl = COUNT_PIN;
			SRC_PIN_N: src_lvl = !COUNT_PIN;
			SRC_INSTR: src_lvl = instr_en;
			SRC_FAST:  src_lvl = FAST_OSC;
			SRC_SLOW:  src_lvl = SLOW_OSC;
			SRC_MED:   src_lvl = MED_OSC;
			SRC_SEC:   src_lvl = SEC_OSC;
			SRC_LCELL: src_lvl = LCELL_OUT;
			default:   src_lvl = 1'b0;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			src_q_ff <= 1'b0;
		end else begin
			src_q_ff <= src_lvl;
		end
	end

	assign src_edge = src_lvl && !src_q_ff;

	// synchronised mode holds an edge until the next instruction cycle
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			pend_ff <= 1'b0;
		end else if (instr_en || unsync) begin
			pend_ff <= 1'b0;
		end else if (src_edge) begin
			pend_ff <= 1'b1;
		end
	end

	assign count_in = unsync ? src_edge
	                         : (instr_en && (pend_ff || src_edge));

	// ----------------------------------------
	// prescaler and postscaler
	// ----------------------------------------
	assign pre_bus.clear   = scl_clr;
	assign pre_bus.tick_in = run && count_in;
	assign pre_bus.ratio   = ctrl1_ff[CS_PRE_HI:CS_PRE_LO];

	tpo_prescale u_pre (
		.clk (REF_CLK),
		.rst (RESET),
		.s   (pre_bus)
	);

	assign step = pre_bus.tick_out && !wr_go;

	assign post_bus.clear   = scl_clr;
	assign post_bus.tick_in = event_hit;
	assign post_bus.ratio   = ctrl0_ff[CF_POST_HI:CF_POST_LO];

	tpo_postscale u_post (
		.clk (REF_CLK),
		.rst (RESET),
		.s   (post_bus)
	);

	// ----------------------------------------
	// counter
	// ----------------------------------------
	assign nxt_count = {cnt_hi_ff, low_ff} + WIDE_ONE;
	assign match     = (low_ff == buf_ff);
	assign event_hit = step && (wide ? ({cnt_hi_ff, low_ff} == WIDE_MAX) : match);

	// a bus write beats a count step in the same cycle
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			low_ff    <= REG_RST;
			cnt_hi_ff <= REG_RST;
		end else if (wr_go && idx == IDX_LOW) begin
			low_ff <= WB_DAT_I[REG_W-1:0];
			if (wide) begin
				cnt_hi_ff <= hi_ff;
			end
		end else if (step && wide) begin
			{cnt_hi_ff, low_ff} <= nxt_count;
		end else if (step) begin
			low_ff <= match ? REG_RST : low_ff + LOW_ONE;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			buf_ff <= REG_RST;
		end else if (step && !wide && match) begin
			buf_ff <= hi_ff;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			hi_ff <= REG_RST;
		end else if (wr_go && idx == IDX_HIGH) begin
			hi_ff <= WB_DAT_I[REG_W-1:0];
		end else if (rd_go && idx == IDX_LOW && wide) begin
			hi_ff <= cnt_hi_ff;
		end
	end

	// ----------------------------------------
	// toggle output and flag
	// ----------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			tog_ff <= 1'b0;
		end else if (post_bus.tick_out) begin
			tog_ff <= !tog_ff;
		end
	end

	// set wins over a software clear in the same cycle
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			flag_ff <= 1'b0;
			ie_ff   <= 1'b0;
		end else begin
			if (post_bus.tick_out) begin
				flag_ff <= 1'b1;
			end else if (wr_go && idx == IDX_IRQ && !WB_DAT_I[IR_FLAG]) begin
				flag_ff <= 1'b0;
			end
			if (wr_go && idx == IDX_IRQ) begin
				ie_ff <= WB_DAT_I[IR_EN];
			end
		end
	end

	assign TOGGLE_OUT = tog_ff;
	assign IRQ_REQ    = flag_ff && ie_ff;
	assign WAKE_REQ   = IRQ_REQ && SLEEP && unsync;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);

	bus_answer_a: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
		else $error("bus request not answered next cycle");
	bus_ack_drop_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held longer than one cycle");
	out_bit_read_a: assert property ((rd_go && idx == IDX_CTRL0)
		|=> WB_DAT_O[CF_OUT] == $past(tog_ff))
		else $error("toggle level not returned on control read");
	flag_on_toggle_a: assert property (($changed(tog_ff)) |-> flag_ff)
		else $error("toggle without flag");
	tog_step_a: assert property (post_bus.tick_out |=> tog_ff != $past(tog_ff))
		else $error("toggle missed a postscaler event");
	flag_keep_a: assert property ((flag_ff && !(wr_go && idx == IDX_IRQ)) |=> flag_ff)
		else $error("flag dropped without a clear");
	sleep_halt_a: assert property ((SLEEP && !unsync && !wr_go) |=> $stable(low_ff))
		else $error("synchronised counter moved in sleep");
	period_match_a: assert property ((step && !wide && match) |=> low_ff == REG_RST)
		else $error("low count not restarted at period");
	high_latch_a: assert property ((rd_go && idx == IDX_LOW && wide)
		|=> hi_ff == $past(cnt_hi_ff))
		else $error("high byte not latched on low read");
	wide_roll_a: assert property ((step && wide && {cnt_hi_ff, low_ff} == WIDE_MAX)
		|=> {cnt_hi_ff, low_ff} == 16'h0000 ##1 tog_ff == $past(tog_ff))
		else $error("sixteen-bit rollover wrong");
	idle_hold_a: assert property ((!run && !wr_go)
		|=> $stable(low_ff) && $stable(tog_ff) && $stable(cnt_hi_ff))
		else $error("disabled timer changed state");

	roll_seen_c: cover property (step && wide && {cnt_hi_ff, low_ff} == WIDE_MAX);
	match_seen_c: cover property (step && !wide && match && buf_ff != REG_RST);
	scaled_toggle_c: cover property (post_bus.tick_out && post_bus.ratio != '0);
	irq_seen_c: cover property (IRQ_REQ ##1 !flag_ff);
endmodule : tpo_top

/* test/tpo_top_tb_top.sv */
`timescale 1ns/100ps
module tpo_top_tb_top;
	import tpo_pkg::*;

	// ----------------------------------------
	// addresses and bench signals
	// ----------------------------------------
	localparam logic [15:0] A_LOW  = {ADR_TOP, IDX_LOW, ADR_LANE};
	localparam logic [15:0] A_HIGH = {ADR_TOP, IDX_HIGH, ADR_LANE};
	localparam logic [15:0] A_C0   = {ADR_TOP, IDX_CTRL0, ADR_LANE};
	localparam logic [15:0] A_C1   = {ADR_TOP, IDX_CTRL1, ADR_LANE};
	localparam logic [15:0] A_IRQ  = {ADR_TOP, IDX_IRQ, ADR_LANE};
	localparam logic [15:0] A_BAD  = {ADR_TOP, 12'h5a1, ADR_LANE};

	logic              ref_clk;
	logic              reset;
	logic              wb_cyc;
	logic              wb_stb;
	logic              wb_we;
	logic [ADR_W-1:0]  wb_adr;
	logic [3:0]        wb_sel;
	logic [DAT_W-1:0]  wb_dat_i;
	logic [DAT_W-1:0]  wb_dat_o;
	logic              wb_ack;
	logic              sleep;
	logic [7:0]        lv;
	logic              toggle_out;
	logic              irq_req;
	logic              wake_req;
	logic [7:0]        q;
	logic [7:0]        v1;
	logic              t;
	int                miscompares;
	int                total_checks;

	tpo_top u_dut (
		.REF_CLK    (ref_clk),
		.RESET      (reset),
		.WB_CYC_I   (wb_cyc),
		.WB_STB_I   (wb_stb),
		.WB_WE_I    (wb_we),
		.WB_ADR_I   (wb_adr),
		.WB_SEL_I   (wb_sel),
		.WB_DAT_I   (wb_dat_i),
		.WB_DAT_O   (wb_dat_o),
		.WB_ACK_O   (wb_ack),
		.SLEEP      (sleep),
		.COUNT_PIN  (lv[0] | lv[1]),
		.FAST_OSC   (lv[3]),
		.SLOW_OSC   (lv[4]),
		.MED_OSC    (lv[5]),
		.SEC_OSC    (lv[6]),
		.LCELL_OUT  (lv[7]),
		.TOGGLE_OUT (toggle_out),
		.IRQ_REQ    (irq_req),
		.WAKE_REQ   (wake_req)
	);

	always #12.5 ref_clk = ~ref_clk;

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task end_of_test;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test

	// one classic cycle; slave latency is not assumed, only bounded
	task automatic xfer(input logic we, input logic [15:0] a, input logic [7:0] d,
			input logic [3:0] s);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= s;
		wb_dat_i <= {24'h000000, d};
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		q = wb_dat_o[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (n >= 50) begin
			miscompares++;
			end_of_test();
		end
	endtask : xfer

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		xfer(1'b1, a, d, 4'h1);
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [7:0] e, input string nm);
		xfer(1'b0, a, 8'h00, 4'hf);
		check(nm, q, e);
	endtask : rd

	// each pulse is one source edge; wide enough for edge detection
	task automatic pulse(input int src, input int cnt);
		for (int i = 0; i < cnt; i++) begin
			@(posedge ref_clk);
			lv[src] <= 1'b1;
			repeat (2) @(posedge ref_clk);
			lv[src] <= 1'b0;
			repeat (2) @(posedge ref_clk);
		end
	endtask : pulse

	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		end_of_test();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		reset = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 16'h0000;
		wb_sel = 4'h0;
		wb_dat_i = 32'h00000000;
		sleep = 1'b0;
		lv = 8'h00;
		miscompares = 0;
		total_checks = 0;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		rd(A_LOW, 8'h00, "low reset");
		rd(A_HIGH, 8'h00, "high reset");
		rd(A_C0, 8'h00, "ctrl0 reset");
		rd(A_C1, 8'h00, "ctrl1 reset");
		rd(A_IRQ, 8'h00, "irq reset");
		xfer(1'b1, A_HIGH, 8'h55, 4'he);
		rd(A_HIGH, 8'h00, "high lane off");
		wr(A_BAD, 8'hff);
		rd(A_BAD, 8'h00, "unmapped");
		wr(A_C0, 8'h60);
		rd(A_C0, 8'h00, "ctrl0 read only");
		// 8-bit mode, async pin, first match uses the reset buffer
		wr(A_HIGH, 8'h03);
		wr(A_C1, 8'h10);
		wr(A_IRQ, 8'h02);
		wr(A_C0, 8'h80);
		pulse(0, 1);
		check("toggle first", {7'h00, toggle_out}, 8'h01);
		rd(A_C0, 8'ha0, "ctrl0 level");
		check("irq req", {7'h00, irq_req}, 8'h01);
		pulse(0, 3);
		rd(A_LOW, 8'h03, "low at period");
		pulse(0, 1);
		rd(A_LOW, 8'h00, "low restart");
		rd(A_IRQ, 8'h03, "flag held");
		check("toggle second", {7'h00, toggle_out}, 8'h00);
		wr(A_IRQ, 8'h02);
		check("irq cleared", {7'h00, irq_req}, 8'h00);
		// every postscaler ratio, period of four steps
		for (int n = 0; n < 16; n++) begin
			wr(A_C0, 8'h80 | 8'(n));
			wr(A_LOW, 8'h00);
			wr(A_IRQ, 8'h02);
			t = toggle_out;
			pulse(0, 4 * n + 3);
			check("toggle early", {7'h00, toggle_out}, {7'h00, t});
			rd(A_IRQ, 8'h02, "flag early");
			pulse(0, 1);
			check("toggle terminal", {7'h00, toggle_out}, {7'h00, ~t});
			rd(A_IRQ, 8'h03, "flag terminal");
		end
		// control write mid-ratio restarts the postscaler
		wr(A_C0, 8'h81);
		wr(A_LOW, 8'h00);
		t = toggle_out;
		pulse(0, 4);
		wr(A_C1, 8'h10);
		pulse(0, 4);
		check("post cleared", {7'h00, toggle_out}, {7'h00, t});
		pulse(0, 4);
		check("post after clear", {7'h00, toggle_out}, {7'h00, ~t});
		// disabled timer ignores edges
		wr(A_C0, 8'h00);
		t = toggle_out;
		pulse(0, 5);
		rd(A_LOW, 8'h00, "low held");
		check("toggle held", {7'h00, toggle_out}, {7'h00, t});
		// 16-bit count, buffered high byte, rollover in sleep
		wr(A_C0, 8'h10);
		wr(A_HIGH, 8'hff);
		wr(A_LOW, 8'hfe);
		wr(A_C0, 8'h90);
		pulse(0, 1);
		rd(A_LOW, 8'hff, "wide low");
		rd(A_HIGH, 8'hff, "wide high");
		wr(A_IRQ, 8'h02);
		t = toggle_out;
		sleep <= 1'b1;
		repeat (2) @(posedge ref_clk);
		check("wake idle", {7'h00, wake_req}, 8'h00);
		pulse(0, 1);
		check("wake", {7'h00, wake_req}, 8'h01);
		check("toggle rollover", {7'h00, toggle_out}, {7'h00, ~t});
		rd(A_LOW, 8'h00, "rollover low");
		rd(A_HIGH, 8'h00, "rollover high");
		// instruction clock, synchronised: frozen in sleep
		wr(A_C1, 8'h40);
		xfer(1'b0, A_LOW, 8'h00, 4'hf);
		v1 = q;
		repeat (40) @(posedge ref_clk);
		rd(A_LOW, v1, "sync sleep hold");
		sleep <= 1'b0;
		repeat (20) @(posedge ref_clk);
		xfer(1'b0, A_LOW, 8'h00, 4'hf);
		check("sync counts", {7'h00, q !== v1}, 8'h01);
		// every edge source; read taken after the switch settles
		for (int s = 0; s < 8; s++) begin
			if (s != 2) begin
				wr(A_C1, {3'(s), 5'h10});
				xfer(1'b0, A_LOW, 8'h00, 4'hf);
				v1 = q;
				pulse(s, 1);
				rd(A_LOW, v1 + 8'h01, "source step");
			end
		end
		// prescale 1:4
		wr(A_C1, 8'h12);
		xfer(1'b0, A_LOW, 8'h00, 4'hf);
		v1 = q;
		pulse(0, 3);
		rd(A_LOW, v1, "prescale hold");
		pulse(0, 1);
		rd(A_LOW, v1 + 8'h01, "prescale out");
		end_of_test();
	end
endmodule : tpo_top_tb_top
